// file: verilog/tmm_trace_mgr.v
// trace memory manager: current and reference traces plus storage slots
`timescale 1ns/1ps
`default_nettype none
`include "tmm_map.vh"
module tmm_trace_mgr #(
    parameter W  = `TMM_DATA_W,
    parameter LW = `TMM_LVL_W,
    parameter NP = `TMM_POINTS,
    parameter AW = 10,
    parameter SW = 14
) (
    input  wire          clk,
    input  wire          reset_n,
    input  wire          video_valid,
    input  wire [W-1:0]  video_data,
    input  wire          point_end,
    input  wire [AW-1:0] point_idx,
    input  wire          sweep_running,
    input  wire          single_mode,
    input  wire          sweep_1s,
    input  wire [AW-1:0] range_lo,
    input  wire [AW-1:0] range_hi,
    input  wire          range_change,
    input  wire          view_a,
    input  wire          view_b,
    input  wire          max_hold,
    input  wire          diff_mode,
    input  wire          diff_ref_set,
    input  wire [W-1:0]  display_line,
    input  wire          cmd_clear_a,
    input  wire          cmd_store_ab,
    input  wire          cmd_copy_ba,
    input  wire          cmd_save,
    input  wire          cmd_recall,
    input  wire [3:0]    slot_digit,
    input  wire [LW-1:0] ref_level,
    input  wire [7:0]    scale_step,
    input  wire [7:0]    scale_recip,
    input  wire [AW-1:0] disp_addr,
    input  wire [AW-1:0] marker_addr,
    output reg  [W-1:0]  disp_a_data_reg,
    output reg           disp_a_vis_reg,
    output reg  [W-1:0]  disp_b_data_reg,
    output reg           disp_b_vis_reg,
    output reg  [W-1:0]  marker_level_reg,
    output reg           marker_on_a_reg,
    output reg           dot_on_reg,
    output reg  [AW-1:0] dot_idx_reg,
    output reg           sweep_restart_reg,
    output reg           sweep_abort_reg,
    output reg           diff_active_reg,
    output reg           overflow_reg,
    output reg           busy_reg
);
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_RUN  = 2'd1;
    localparam [1:0] ST_LAST = 2'd2;
    localparam [1:0] ST_SAMP = 2'd3;
    localparam [AW-1:0] LAST_PT = NP - 1;

    reg [1:0]    state_reg;
    reg [2:0]    op_reg;
    reg [AW-1:0] cnt_reg;
    reg [AW-1:0] wa_reg;
    reg          wv_reg;
    reg [SW-1:0] slot_base_reg;
    reg [W-1:0]  zero_reg;
    reg [W-1:0]  samp_reg;
    reg [AW-1:0] samp_idx_reg;
    reg [AW-1:0] disp_addr_d_reg;

    wire          pk_valid;
    wire [W-1:0]  pk_data;
    wire [AW-1:0] pk_idx;
    wire [W-1:0]  a_r0;
    wire [W-1:0]  a_r1;
    wire [W-1:0]  b_r0;
    wire [W-1:0]  b_r1;
    wire [LW-1:0] s_r;

    reg          a_we;
    reg [AW-1:0] a_wa;
    reg [W-1:0]  a_wd;
    reg          b_we;
    reg [W-1:0]  b_wd;
    reg          s_we;
    reg [LW-1:0] s_wd;
    reg          ovf_set;
    reg [W+1:0]  sum;
    reg [16:0]   prod;
    reg [LW+8:0] rprod;
    reg [LW:0]   dlev;
    reg [LW+8:0] rv;

    wire [AW-1:0] rd_addr = (state_reg == ST_IDLE) ? pk_idx : cnt_reg;
    wire [SW-1:0] s_raddr = slot_base_reg + {{(SW-AW){1'b0}}, cnt_reg};
    wire [SW-1:0] s_waddr = slot_base_reg + {{(SW-AW){1'b0}}, wa_reg};
    wire in_range_pk = (pk_idx >= range_lo) && (pk_idx <= range_hi);
    wire in_range_wa = (wa_reg >= range_lo) && (wa_reg <= range_hi);
    wire [31:0]   slot_mul = slot_digit * NP;

    // ------------------------------------------------------------
    // peak detector and memories
    // ------------------------------------------------------------
    tmm_peak #(.W(W), .AW(AW)) u_peak (
        .clk            (clk),
        .reset_n        (reset_n),
        .video_valid    (video_valid),
        .video_data     (video_data),
        .point_end      (point_end),
        .point_idx      (point_idx),
        .peak_valid_reg (pk_valid),
        .peak_data_reg  (pk_data),
        .peak_idx_reg   (pk_idx)
    );

    tmm_ram #(.W(W), .D(NP), .AW(AW)) u_mem_a (
        .clk    (clk),
        .we     (a_we),
        .waddr  (a_wa),
        .wdata  (a_wd),
        .raddr0 (disp_addr),
        .rdata0 (a_r0),
        .raddr1 (rd_addr),
        .rdata1 (a_r1)
    );

    tmm_ram #(.W(W), .D(NP), .AW(AW)) u_mem_b (
        .clk    (clk),
        .we     (b_we),
        .waddr  (wa_reg),
        .wdata  (b_wd),
        .raddr0 (disp_addr),
        .rdata0 (b_r0),
        .raddr1 (rd_addr),
        .rdata1 (b_r1)
    );

    tmm_ram #(.W(LW), .D(NP*`TMM_SLOTS), .AW(SW)) u_mem_slot (
        .clk    (clk),
        .we     (s_we),
        .waddr  (s_waddr),
        .wdata  (s_wd),
        .raddr0 (s_raddr),
        .rdata0 (),
        .raddr1 (s_raddr),
        .rdata1 (s_r)
    );

    // ------------------------------------------------------------
    // write data paths
    // ------------------------------------------------------------
    // one bulk location or one sample written per cycle
    always @* begin
        a_we    = 1'b0;
        a_wa    = wa_reg;
        a_wd    = `TMM_MIN_VAL;
        b_we    = 1'b0;
        b_wd    = a_r1;
        s_we    = 1'b0;
        s_wd    = {LW{1'b0}};
        ovf_set = 1'b0;
        sum     = {(W+2){1'b0}};
        prod    = 17'h00000;
        rprod   = {(LW+9){1'b0}};
        dlev    = {(LW+1){1'b0}};
        rv      = {(LW+9){1'b0}};
        if (state_reg == ST_SAMP) begin
            a_wa = samp_idx_reg;
            if (diff_active_reg)
                sum = {2'b00, samp_reg} - {2'b00, b_r1}
                      + {2'b00, zero_reg};
            else
                sum = {2'b00, samp_reg};
            a_wd    = sum[W-1:0]; // wraps on overflow
            ovf_set = sum[W+1] | sum[W];
            // max-hold keeps the larger of stored and new
            a_we = !max_hold || (sum[W-1:0] > a_r1);
        end else if (wv_reg) begin
            case (op_reg)
            `TMM_OP_CLEAR: a_we = 1'b1;
            `TMM_OP_STORE: b_we = 1'b1;
            `TMM_OP_COPY: begin
                a_we = 1'b1;
                a_wd = b_r1;
            end
            `TMM_OP_DIFF_ON: begin
                sum  = {2'b00, a_r1} - {2'b00, b_r1}
                       + {2'b00, zero_reg};
                a_we = 1'b1;
                a_wd = sum[W-1:0];
                ovf_set = sum[W+1] | sum[W];
            end
            `TMM_OP_DIFF_OFF: begin
                // wrapped differences come back intact; the sum wraps the same way
                sum  = {2'b00, a_r1} + {2'b00, b_r1}
                       - {2'b00, zero_reg};
                a_we = 1'b1;
                a_wd = sum[W-1:0];
            end
            `TMM_OP_BLANK: a_we = !in_range_wa;
            `TMM_OP_SAVE: begin
                if (diff_active_reg)
                    prod = $signed({1'b0, a_r1} - {1'b0, zero_reg})
                           * $signed({1'b0, scale_step});
                else
                    prod = $signed({1'b0, a_r1} - {1'b0, `TMM_TOP_VAL})
                           * $signed({1'b0, scale_step});
                s_we = 1'b1;
                s_wd = diff_active_reg ? prod[LW-1:0]
                       : ref_level + prod[LW-1:0];
            end
            `TMM_OP_RECALL: begin
                dlev  = {s_r[LW-1], s_r} - {ref_level[LW-1], ref_level};
                rprod = $signed(dlev) * $signed({1'b0, scale_recip});
                rv    = $signed({{(W+1){1'b0}}, `TMM_TOP_VAL})
                        + ($signed(rprod) >>> `TMM_RECIP_SHIFT);
                b_we  = 1'b1;
                // clamp to the visible range
                if (rv[LW+8])
                    b_wd = `TMM_MIN_VAL;
                else if (rv > {{(LW+1){1'b0}}, `TMM_TOP_VAL})
                    b_wd = `TMM_TOP_VAL;
                else
                    b_wd = rv[W-1:0];
            end
            default: a_we = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control sequencer
    // ------------------------------------------------------------
    // commands are taken only while idle; samples are taken only in idle cycles with no command accepted, else dropped
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg         <= ST_IDLE;
            op_reg            <= `TMM_OP_CLEAR;
            cnt_reg           <= {AW{1'b0}};
            wa_reg            <= {AW{1'b0}};
            wv_reg            <= 1'b0;
            slot_base_reg     <= {SW{1'b0}};
            zero_reg          <= `TMM_ZERO_MID;
            samp_reg          <= {W{1'b0}};
            samp_idx_reg      <= {AW{1'b0}};
            diff_active_reg   <= 1'b0;
            overflow_reg      <= 1'b0;
            busy_reg          <= 1'b0;
            sweep_restart_reg <= 1'b0;
            sweep_abort_reg   <= 1'b0;
        end else begin
            sweep_restart_reg <= 1'b0;
            sweep_abort_reg   <= 1'b0;
            wa_reg            <= cnt_reg;
            // overflow set wins over clear in the same cycle
            if (ovf_set)
                overflow_reg <= 1'b1;
            else if (state_reg == ST_IDLE && cmd_clear_a)
                overflow_reg <= 1'b0;
            if (diff_ref_set)
                zero_reg <= display_line;
            case (state_reg)
            ST_IDLE: begin
                cnt_reg <= {AW{1'b0}};
                wv_reg  <= 1'b0;
                if (cmd_clear_a) begin
                    op_reg    <= `TMM_OP_CLEAR;
                    state_reg <= ST_RUN;
                    busy_reg  <= 1'b1;
                    sweep_restart_reg <= sweep_running
                                         && !single_mode;
                    sweep_abort_reg   <= sweep_running
                                         && single_mode;
                end else if (cmd_store_ab || cmd_copy_ba) begin
                    op_reg    <= cmd_store_ab ? `TMM_OP_STORE
                                              : `TMM_OP_COPY;
                    state_reg <= ST_RUN;
                    busy_reg  <= 1'b1;
                end else if (diff_mode != diff_active_reg) begin
                    op_reg <= diff_mode ? `TMM_OP_DIFF_ON
                                        : `TMM_OP_DIFF_OFF;
                    diff_active_reg <= diff_mode;
                    state_reg <= ST_RUN;
                    busy_reg  <= 1'b1;
                end else if (range_change) begin
                    op_reg    <= `TMM_OP_BLANK;
                    state_reg <= ST_RUN;
                    busy_reg  <= 1'b1;
                end else if ((cmd_save || cmd_recall)
                             && slot_digit <= `TMM_LAST_SLOT) begin
                    op_reg <= cmd_save ? `TMM_OP_SAVE
                                       : `TMM_OP_RECALL;
                    slot_base_reg <= slot_mul[SW-1:0];
                    state_reg <= ST_RUN;
                    busy_reg  <= 1'b1;
                end else if (pk_valid && in_range_pk) begin
                    samp_reg     <= pk_data;
                    samp_idx_reg <= pk_idx;
                    state_reg    <= ST_SAMP;
                end
            end
            ST_RUN: begin
                wv_reg <= 1'b1;
                if (cnt_reg == LAST_PT)
                    state_reg <= ST_LAST;
                else
                    cnt_reg <= cnt_reg + 1'b1;
            end
            ST_LAST: begin
                wv_reg    <= 1'b0;
                busy_reg  <= 1'b0;
                state_reg <= ST_IDLE;
            end
            ST_SAMP: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // display, marker and sweep dot
    // ------------------------------------------------------------
    // flags gate the readout only; memory is never touched here
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            disp_a_data_reg  <= {W{1'b0}};
            disp_a_vis_reg   <= 1'b0;
            disp_b_data_reg  <= {W{1'b0}};
            disp_b_vis_reg   <= 1'b0;
            marker_level_reg <= {W{1'b0}};
            marker_on_a_reg  <= 1'b0;
            dot_on_reg       <= 1'b0;
            dot_idx_reg      <= {AW{1'b0}};
            disp_addr_d_reg  <= {AW{1'b0}};
        end else begin
            disp_addr_d_reg <= disp_addr;
            disp_a_data_reg <= a_r0;
            disp_a_vis_reg  <= view_a;
            disp_b_data_reg <= b_r0;
            disp_b_vis_reg  <= view_b;
            marker_on_a_reg <= 1'b1;
            if (disp_addr_d_reg == marker_addr)
                marker_level_reg <= a_r0;
            dot_on_reg  <= sweep_running && sweep_1s && view_a;
            dot_idx_reg <= point_idx;
        end
    end
endmodule // tmm_trace_mgr
`default_nettype wire

// file: verilog/tmm_map.vh
// constants shared by the trace memory manager files
`ifndef TMM_MAP_VH
`define TMM_MAP_VH
// ----------------------------------------------------------------
// trace geometry
// ----------------------------------------------------------------
`define TMM_POINTS      1000
`define TMM_SLOTS       10
`define TMM_DATA_W      8
`define TMM_LVL_W       16
`define TMM_MIN_VAL     8'h00
`define TMM_TOP_VAL     8'hff
`define TMM_ZERO_MID    8'h80
`define TMM_LAST_SLOT   4'h9
`define TMM_RECIP_SHIFT 8
// ----------------------------------------------------------------
// bulk operation codes
// ----------------------------------------------------------------
`define TMM_OP_CLEAR    3'h0
`define TMM_OP_STORE    3'h1
`define TMM_OP_COPY     3'h2
`define TMM_OP_DIFF_ON  3'h3
`define TMM_OP_DIFF_OFF 3'h4
`define TMM_OP_BLANK    3'h5
`define TMM_OP_SAVE     3'h6
`define TMM_OP_RECALL   3'h7
`endif

// file: verilog/tmm_ram.v
// simple memory with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module tmm_ram #(
    parameter W  = 8,
    parameter D  = 1000,
    parameter AW = 10
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [W-1:0]  wdata,
    input  wire [AW-1:0] raddr0,
    output reg  [W-1:0]  rdata0,
    input  wire [AW-1:0] raddr1,
    output reg  [W-1:0]  rdata1
);
    reg [W-1:0] mem [0:D-1];

    // read data registered; contents need no reset
    always @(posedge clk) begin
        if (we)
            mem[waddr] <= wdata;
        rdata0 <= mem[raddr0];
        rdata1 <= mem[raddr1];
    end
endmodule // tmm_ram
`default_nettype wire

// file: verilog/tmm_peak.v
// positive peak detector over one trace point interval
`timescale 1ns/1ps
`default_nettype none
module tmm_peak #(
    parameter W  = 8,
    parameter AW = 10
) (
    input  wire          clk,
    input  wire          reset_n,
    input  wire          video_valid,
    input  wire [W-1:0]  video_data,
    input  wire          point_end,
    input  wire [AW-1:0] point_idx,
    output reg           peak_valid_reg,
    output reg  [W-1:0]  peak_data_reg,
    output reg  [AW-1:0] peak_idx_reg
);
    reg [W-1:0] acc_reg;
    reg         any_reg;
    wire        bigger = video_valid && (!any_reg || video_data > acc_reg);
    wire [W-1:0] cur_max = bigger ? video_data : acc_reg;

    // hold the largest sample, restart at every point boundary
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg        <= {W{1'b0}};
            any_reg        <= 1'b0;
            peak_valid_reg <= 1'b0;
            peak_data_reg  <= {W{1'b0}};
            peak_idx_reg   <= {AW{1'b0}};
        end else begin
            peak_valid_reg <= point_end;
            if (point_end) begin
                peak_data_reg <= cur_max;
                peak_idx_reg  <= point_idx;
                acc_reg       <= {W{1'b0}};
                any_reg       <= 1'b0;
            end else if (bigger) begin
                acc_reg <= video_data;
                any_reg <= 1'b1;
            end
        end
    end
endmodule // tmm_peak
`default_nettype wire

// file: sim/tmm_trace_mgr_props.sv
// port-level assertions for the trace memory manager
`timescale 1ns/1ps
`default_nettype none
module tmm_trace_mgr_props #(
    parameter NP = 1000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic point_end,
    input wire logic sweep_running,
    input wire logic single_mode,
    input wire logic sweep_1s,
    input wire logic view_a,
    input wire logic view_b,
    input wire logic cmd_clear_a,
    input wire logic disp_a_vis_reg,
    input wire logic disp_b_vis_reg,
    input wire logic marker_on_a_reg,
    input wire logic dot_on_reg,
    input wire logic sweep_restart_reg,
    input wire logic sweep_abort_reg,
    input wire logic overflow_reg,
    input wire logic busy_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    int unsigned busy_len_reg;
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    // length of a busy stretch; a repeat cannot count a thousand cycles
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            busy_len_reg <= 0;
        else if (busy_reg)
            busy_len_reg <= busy_len_reg + 1;
        else
            busy_len_reg <= 0;
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // clear taken only when idle and no sample write is in flight
    sequence s_take;
        cmd_clear_a && !busy_reg && !$past(busy_reg) && !$past(point_end)
            && !$past(point_end, 2) && !$past(point_end, 3);
    endsequence
    sequence s_cont;
        sweep_running && !single_mode;
    endsequence
    sequence s_single;
        sweep_running && single_mode;
    endsequence
    AST_CLEAR_BUSY: assert property (s_take |=> busy_reg [*8])
        else $error("clear did not start a bulk pass");
    AST_BULK_LEN: assert property ($fell(busy_reg) |-> busy_len_reg == NP + 1)
        else $error("bulk pass length wrong");
    AST_RESTART: assert property (s_take ##0 s_cont |=> sweep_restart_reg)
        else $error("no restart after clear");
    AST_ABORT: assert property (s_take ##0 s_single |=> sweep_abort_reg && !sweep_restart_reg)
        else $error("no abort after clear");
    AST_PULSE: assert property ((sweep_restart_reg || sweep_abort_reg) |-> $past(cmd_clear_a) ##1 !(sweep_restart_reg || sweep_abort_reg))
        else $error("restart or abort pulse malformed");
    AST_VIEW: assert property ($past(reset_n) |-> disp_a_vis_reg == $past(view_a) && disp_b_vis_reg == $past(view_b))
        else $error("view flags not passed to display");
    AST_DOT: assert property (!$past(sweep_1s) || !$past(sweep_running) |-> !dot_on_reg)
        else $error("dot shown for short or idle sweep");
    AST_MARKER: assert property ($past(reset_n) |-> marker_on_a_reg)
        else $error("marker left the current trace");
    AST_OVF: assert property ($fell(overflow_reg) |-> busy_reg)
        else $error("overflow dropped outside a clear");
endmodule // tmm_trace_mgr_props
bind tmm_trace_mgr tmm_trace_mgr_props #(.NP(NP)) tmm_trace_mgr_props_inst (
    .clk, .reset_n, .point_end, .sweep_running, .single_mode, .sweep_1s,
    .view_a, .view_b, .cmd_clear_a, .disp_a_vis_reg, .disp_b_vis_reg,
    .marker_on_a_reg, .dot_on_reg, .sweep_restart_reg, .sweep_abort_reg,
    .overflow_reg, .busy_reg
);
`default_nettype wire

// file: sim/tmm_sweep_model.sv
// sweep digitizer and display refresh stand-in
`timescale 1ns/1ps
`default_nettype none
module tmm_sweep_model (
    input  wire logic       clk,
    output var  logic       video_valid,
    output var  logic [7:0] video_data,
    output var  logic       point_end,
    output var  logic [9:0] point_idx,
    output var  logic [9:0] disp_addr
);
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    // quiet lines at time zero
    initial begin
        video_valid = 1'b0;
        video_data = 8'h00;
        point_end = 1'b0;
        point_idx = 10'h000;
        disp_addr = 10'h000;
    end
    // one point interval: larger sample first, so peak must hold it
    task automatic put(input logic [9:0] i, input logic [7:0] v);
        @(posedge clk);
        video_valid <= 1'b1;
        video_data <= v;
        point_idx <= i;
        @(posedge clk);
        video_data <= v >> 1;
        @(posedge clk);
        video_valid <= 1'b0;
        video_data <= ~(v >> 1);
        point_end <= 1'b1;
        @(posedge clk);
        point_end <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // refresh visits one address and holds it until data settles
    task automatic look(input logic [9:0] a);
        @(posedge clk);
        disp_addr <= a;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule // tmm_sweep_model
`default_nettype wire

// file: sim/test_trace_memory_manager.sv
// self-checking bench for the trace memory manager
`timescale 1ns/1ps
`default_nettype none
module test_trace_memory_manager;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sweep_running = 1'b1;
    logic        single_mode = 1'b0;
    logic        sweep_1s = 1'b0;
    logic        view_a = 1'b1;
    logic        view_b = 1'b1;
    logic        max_hold = 1'b0;
    logic        diff_mode = 1'b0;
    logic [6:0]  pv = 7'h00;
    logic [3:0]  slot_digit = 4'h0;
    logic [9:0]  range_lo = 10'h000;
    logic [15:0] ref_level = 16'h0000;
    logic        video_valid, point_end;
    logic [7:0]  video_data;
    logic [9:0]  point_idx, disp_addr, dot_idx_reg;
    logic [7:0]  disp_a_data_reg, disp_b_data_reg, marker_level_reg;
    logic        disp_a_vis_reg, disp_b_vis_reg, dot_on_reg;
    logic        diff_active_reg, overflow_reg, busy_reg;
    int          n_mismatch = 0;
    int          tests_run = 0;
    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    // 100 MHz system clock
    initial begin
        forever #5 clk = ~clk;
    end
    // pv bits: clear, store, copy, save, recall, range, zero level
    tmm_trace_mgr tmm_trace_mgr_inst (
        .clk, .reset_n, .video_valid, .video_data, .point_end, .point_idx,
        .sweep_running, .single_mode, .sweep_1s, .range_lo,
        .range_hi(10'h3e7), .range_change(pv[5]), .view_a, .view_b,
        .max_hold, .diff_mode, .diff_ref_set(pv[6]),
        .display_line(8'h70), .cmd_clear_a(pv[0]), .cmd_store_ab(pv[1]),
        .cmd_copy_ba(pv[2]), .cmd_save(pv[3]), .cmd_recall(pv[4]),
        .slot_digit, .ref_level, .scale_step(8'h02), .scale_recip(8'h80),
        .disp_addr, .marker_addr(10'h005), .disp_a_data_reg,
        .disp_a_vis_reg, .disp_b_data_reg, .disp_b_vis_reg,
        .marker_level_reg, .marker_on_a_reg(), .dot_on_reg, .dot_idx_reg,
        .sweep_restart_reg(), .sweep_abort_reg(), .diff_active_reg,
        .overflow_reg, .busy_reg
    );
    tmm_sweep_model tmm_sweep_model_inst (
        .clk, .video_valid, .video_data, .point_end, .point_idx, .disp_addr
    );
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic look_ab(input logic [9:0] i, input logic [7:0] ea,
                           input logic [7:0] eb);
        tmm_sweep_model_inst.look(i);
        check("trace_a", ea, disp_a_data_reg);
        check("trace_b", eb, disp_b_data_reg);
    endtask
    // bounded waits: busy must rise soon, a pass is about 1000 cycles
    task automatic wait_idle;
        int i;
        i = 0;
        while (busy_reg !== 1'b1 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        i = 0;
        while (busy_reg !== 1'b0 && i < 1100) begin
            @(posedge clk);
            #1;
            i++;
        end
        check("pass_len", 8'h01, {7'h00, i > 0 && i < 1100});
        @(posedge clk);
    endtask
    task automatic fire(input logic [6:0] v, input bit bulk);
        @(posedge clk);
        pv <= v;
        @(posedge clk);
        pv <= 7'h00;
        if (bulk)
            wait_idle();
    endtask
    task automatic put(input logic [9:0] i, input logic [7:0] v);
        tmm_sweep_model_inst.put(i, v);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, well past the expected run
    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        fire(7'h01, 1);
        put(10'd5, 8'h40);
        fire(7'h02, 1);
        look_ab(10'd5, 8'h40, 8'h40);
        check("marker", 8'h40, marker_level_reg);
        look_ab(10'd6, 8'h00, 8'h00);
        @(posedge clk) single_mode <= 1'b1;
        fire(7'h01, 1);
        look_ab(10'd5, 8'h00, 8'h40);
        @(posedge clk) single_mode <= 1'b0;
        put(10'd5, 8'h30);
        look_ab(10'd5, 8'h30, 8'h40);
        @(posedge clk) view_a <= 1'b0;
        @(posedge clk) view_b <= 1'b0;
        put(10'd6, 8'h22);
        look_ab(10'd6, 8'h22, 8'h00);
        check("vis_a", 8'h00, {7'h00, disp_a_vis_reg});
        check("vis_b", 8'h00, {7'h00, disp_b_vis_reg});
        @(posedge clk) view_a <= 1'b1;
        @(posedge clk) view_b <= 1'b1;
        @(posedge clk) max_hold <= 1'b1;
        put(10'd5, 8'h20);
        look_ab(10'd5, 8'h30, 8'h40);
        put(10'd5, 8'h50);
        look_ab(10'd5, 8'h50, 8'h40);
        @(posedge clk) max_hold <= 1'b0;
        fire(7'h04, 1);
        look_ab(10'd5, 8'h40, 8'h40);
        // difference with the zero level moved to 0x70
        put(10'd6, 8'h90);
        fire(7'h40, 0);
        @(posedge clk) diff_mode <= 1'b1;
        wait_idle();
        look_ab(10'd5, 8'h70, 8'h40);
        look_ab(10'd6, 8'h00, 8'h00);
        check("overflow", 8'h01, {7'h00, overflow_reg});
        check("diff_on", 8'h01, {7'h00, diff_active_reg});
        @(posedge clk) view_a <= 1'b0;
        put(10'd5, 8'h60);
        look_ab(10'd5, 8'h90, 8'h40);
        @(posedge clk) view_a <= 1'b1;
        @(posedge clk) diff_mode <= 1'b0;
        wait_idle();
        look_ab(10'd5, 8'h60, 8'h40);
        check("diff_off", 8'h00, {7'h00, diff_active_reg});
        check("overflow", 8'h01, {7'h00, overflow_reg});
        fire(7'h01, 1);
        check("overflow", 8'h00, {7'h00, overflow_reg});
        @(posedge clk) sweep_1s <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("dot", 8'h01, {7'h00, dot_on_reg});
        check("dot_idx", 8'h05, dot_idx_reg[7:0]);
        @(posedge clk) sweep_1s <= 1'b0;
        // window shrink while stopped erases the lost points
        put(10'd5, 8'h33);
        @(posedge clk) sweep_running <= 1'b0;
        @(posedge clk) range_lo <= 10'd10;
        fire(7'h20, 1);
        put(10'd5, 8'h44);
        @(posedge clk) range_lo <= 10'd0;
        look_ab(10'd5, 8'h00, 8'h40);
        @(posedge clk) sweep_running <= 1'b1;
        // two slots, then recall with a shifted level
        put(10'd20, 8'h5a);
        @(posedge clk) slot_digit <= 4'd3;
        fire(7'h08, 1);
        put(10'd20, 8'h33);
        @(posedge clk) slot_digit <= 4'd9;
        fire(7'h08, 1);
        fire(7'h10, 1);
        look_ab(10'd20, 8'h33, 8'h33);
        @(posedge clk) slot_digit <= 4'd3;
        @(posedge clk) ref_level <= 16'h0020;
        fire(7'h10, 1);
        look_ab(10'd20, 8'h33, 8'h4a);
        @(posedge clk) slot_digit <= 4'd12;
        fire(7'h10, 0);
        repeat (3) @(posedge clk);
        #1;
        check("busy", 8'h00, {7'h00, busy_reg});
        report_and_stop();
    end
endmodule // test_trace_memory_manager
`default_nettype wire
